// file: hdl/tpe_pkg.sv
package tpe_pkg;

  localparam int ADR_W = 8;
  localparam int DAT_W = 32;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_TAR    = 8'h04;
  localparam logic [7:0] ADR_CMD    = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0c;
  localparam logic [7:0] ADR_RXDATA = 8'h10;
  localparam logic [7:0] ADR_SADDR  = 8'h14;
  localparam logic [7:0] ADR_STX    = 8'h18;
  localparam logic [7:0] ADR_SRX    = 8'h1c;

  // Control bits
  localparam int CTRL_EN   = 0;
  localparam int CTRL_RSEN = 1;
  localparam int CTRL_SB   = 2;
  localparam int CTRL_SLV  = 3;
  localparam logic CTRL_RSEN_RST = 1'b1;

  // Command word fields
  localparam int CMD_W     = 11;
  localparam int CMD_RD    = 8;
  localparam int CMD_STOP  = 9;
  localparam int CMD_RS    = 10;

  // Status bits
  localparam int ST_CMDV   = 0;
  localparam int ST_RXV    = 1;
  localparam int ST_NACK   = 2;
  localparam int ST_ARB    = 3;
  localparam int ST_BUSY   = 4;
  localparam int ST_ACTIVE = 5;
  localparam int ST_SRXV   = 6;
  localparam int ST_HOLD   = 7;

  localparam logic [7:0] SB_BYTE = 8'h01;

  // Bus timing, 100 kHz class
  localparam int CLK_NS    = 100;
  localparam int T_LOW_NS  = 4700;
  localparam int T_HIGH_NS = 4000;
  localparam logic [7:0] LOW_CYC  = 8'((T_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HIGH_CYC = 8'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SDA_CYC  = 8'h01;

  typedef enum logic [3:0] {
    M_IDLE, M_START, M_LOW, M_RISE, M_HIGH, M_HOLD,
    M_RS_LOW, M_RS_RISE, M_RS_HIGH,
    M_STOP_LOW, M_STOP_RISE, M_STOP_HIGH, M_LOST
  } tpe_ms_e;

  typedef enum logic [1:0] {K_SB, K_ADDR, K_WR, K_RD} tpe_kind_e;

  typedef enum logic [2:0] {P_IDLE, P_ADDR, P_RX, P_TX, P_IGN} tpe_sph_e;

  typedef struct packed {
    logic              en;
    logic              rs_en;
    logic              sb_en;
    logic              sl_en;
    logic [6:0]        tar;
    logic [6:0]        own;
    logic              cmd_v;
    logic [CMD_W-1:0]  cmd;
    logic [7:0]        rx;
    logic              rx_v;
    logic              nack;
    logic              arb_lost;
    logic [7:0]        slv_tx;
    logic [7:0]        slv_rx;
    logic              slv_rx_v;
    logic              ack;
    logic [DAT_W-1:0]  dat;
    tpe_ms_e           ms;
    logic [7:0]        cnt;
    logic [3:0]        bitn;
    logic [7:0]        sh;
    tpe_kind_e         kind;
    logic              last;
    logic              ackb;
    logic              cur_rd;
    logic              m_scl_low;
    logic              m_sda_low;
    logic              bus_busy;
    tpe_sph_e          s_ph;
    logic [3:0]        s_bit;
    logic [7:0]        s_sh;
    logic              s_low;
  } tpe_state_s;

endpackage

// file: hdl/tpe_sync.sv
`timescale 1ns/100ps
`default_nettype none
module tpe_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  import tpe_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } tpe_sync_s;

  tpe_sync_s q;
  tpe_sync_s d;

  // Only the second stage looks at the first
  always_comb begin
    d = q;
    d.s1 = d_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  // Lines idle high, so reset to high avoids a false edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign lvl_o  = q.s2;
  assign rise_o = q.s2 & ~q.s3;
  assign fall_o = ~q.s2 & q.s3;
endmodule
`default_nettype wire

// file: hdl/tpe_host.sv
// Overview of operation
// - Data moves in bytes, unlimited count
// - Slave receiver acks address and data
// - Master stops on missing acknowledge
// - Non-acking slave leaves SDA high
// - Master receiver nacks only final byte
// - Slave transmitter releases SDA on nack
// - Target address changes only while disabled
// - Slave ignores start byte, resets on restart
// - No start while bus is busy
// - Arbitration on SDA while SCL high
// - No arbitration across start or stop
// - Wait for SCL high before high count
// - Shortest high ends, longest low wins
// - Tolerate slaves stretching SCL low
// - Address byte: bits 7:1 address, bit 0 direction
`timescale 1ns/100ps
`default_nettype none
module tpe_host (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [tpe_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [tpe_pkg::DAT_W-1:0] wb_dat_i,
  input  wire logic [3:0]                wb_sel_i,
  output logic      [tpe_pkg::DAT_W-1:0] wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      scl_i,
  output logic                           scl_o,
  output logic                           scl_oe_n_o,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe_n_o
);
  import tpe_pkg::*;

  function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] old_v,
                                             input logic [DAT_W-1:0] new_v,
                                             input logic [3:0]       sel);
    logic [DAT_W-1:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  tpe_state_s q;
  tpe_state_s d;
  logic [1:0] sy_lvl;
  logic [1:0] sy_rise;
  logic [1:0] sy_fall;
  logic [DAT_W-1:0] rv;
  logic [DAT_W-1:0] wv;
  logic       scl_s;
  logic       sda_s;
  logic       start_det;
  logic       stop_det;
  logic       req;
  logic       wr_fire;
  logic       rd_fire;
  logic       lost;
  logic       byte_end;
  logic       ld_addr;
  logic       ld_data;
  logic [3:0] nb;

  tpe_sync #(.W(2)) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .d_i    ({sda_i, scl_i}),
    .lvl_o  (sy_lvl),
    .rise_o (sy_rise),
    .fall_o (sy_fall)
  );

  always_comb begin
    d         = q;
    scl_s     = sy_lvl[0];
    sda_s     = sy_lvl[1];
    start_det = sy_fall[1] & scl_s;
    stop_det  = sy_rise[1] & scl_s;
    req       = wb_cyc_i & wb_stb_i;
    wr_fire   = req & q.ack & wb_we_i;
    rd_fire   = req & q.ack & ~wb_we_i;
    lost      = 1'b0;
    byte_end  = 1'b0;
    ld_addr   = 1'b0;
    ld_data   = 1'b0;
    nb        = q.s_bit + 4'h1;
    rv        = '0;
    case (wb_adr_i)
      ADR_CTRL: begin
        rv[CTRL_EN]   = q.en;
        rv[CTRL_RSEN] = q.rs_en;
        rv[CTRL_SB]   = q.sb_en;
        rv[CTRL_SLV]  = q.sl_en;
      end
      ADR_TAR:    rv[6:0] = q.tar;
      ADR_CMD:    rv[CMD_W-1:0] = q.cmd;
      ADR_STATUS: begin
        rv[ST_CMDV]   = q.cmd_v;
        rv[ST_RXV]    = q.rx_v;
        rv[ST_NACK]   = q.nack;
        rv[ST_ARB]    = q.arb_lost;
        rv[ST_BUSY]   = q.bus_busy;
        rv[ST_ACTIVE] = (q.ms != M_IDLE);
        rv[ST_SRXV]   = q.slv_rx_v;
        rv[ST_HOLD]   = (q.ms == M_HOLD);
      end
      ADR_RXDATA: rv[7:0] = q.rx;
      ADR_SADDR:  rv[6:0] = q.own;
      ADR_STX:    rv[7:0] = q.slv_tx;
      ADR_SRX:    rv[7:0] = q.slv_rx;
      default:    rv = '0;
    endcase
    wv    = merge(rv, wb_dat_i, wb_sel_i);
    d.ack = req & ~q.ack;
    if (req && !q.ack) begin
      d.dat = rv;
    end

    // Clears go first so that hardware sets below win
    if (rd_fire && wb_adr_i == ADR_RXDATA) begin
      d.rx_v = 1'b0;
    end
    if (rd_fire && wb_adr_i == ADR_SRX) begin
      d.slv_rx_v = 1'b0;
    end
    if (wr_fire && wb_adr_i == ADR_STATUS) begin
      if (wv[ST_NACK]) d.nack = 1'b0;
      if (wv[ST_ARB])  d.arb_lost = 1'b0;
    end

    if (start_det) begin
      d.bus_busy = 1'b1;
    end else if (stop_det) begin
      d.bus_busy = 1'b0;
    end

    case (q.ms)
      M_IDLE: begin
        d.m_scl_low = 1'b0;
        d.m_sda_low = 1'b0;
        if (q.en && q.cmd_v && !q.bus_busy) begin
          d.ms        = M_START;
          d.m_sda_low = 1'b1;
          d.cnt       = '0;
        end
      end
      M_START: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == HIGH_CYC) begin
          if (q.sb_en) begin
            d.sh        = SB_BYTE;
            d.kind      = K_SB;
            d.bitn      = '0;
            d.cnt       = '0;
            d.m_scl_low = 1'b1;
            d.ms        = M_LOW;
          end else begin
            ld_addr = 1'b1;
          end
        end
      end
      M_LOW: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == SDA_CYC) begin
          if (q.bitn[3]) begin
            d.m_sda_low = (q.kind == K_RD) & ~q.last;
          end else begin
            d.m_sda_low = (q.kind != K_RD) & ~q.sh[7];
          end
        end
        if (q.cnt == LOW_CYC) begin
          d.m_scl_low = 1'b0;
          d.ms        = M_RISE;
        end
      end
      M_RISE: begin
        if (scl_s) begin
          d.ms  = M_HIGH;
          d.cnt = '0;
        end
      end
      M_HIGH: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == '0) begin
          if (q.bitn[3]) begin
            d.ackb = sda_s;
          end else begin
            d.sh = {q.sh[6:0], sda_s};
            lost = (q.kind != K_RD) & ~q.m_sda_low & ~sda_s;
          end
        end
        if (lost) begin
          d.ms        = M_LOST;
          d.m_scl_low = 1'b0;
          d.m_sda_low = 1'b0;
          d.arb_lost  = 1'b1;
          d.cmd_v     = 1'b0;
        end else if (q.cnt == HIGH_CYC || (q.cnt != '0 && !scl_s)) begin
          d.m_scl_low = 1'b1;
          d.cnt       = '0;
          if (!q.bitn[3]) begin
            d.bitn = q.bitn + 4'h1;
            d.ms   = M_LOW;
          end else begin
            byte_end = 1'b1;
          end
        end
      end
      M_HOLD: begin
        d.m_scl_low = 1'b1;
        if (q.cmd_v) begin
          d.cnt = '0;
          if (q.cmd[CMD_RS] || q.cmd[CMD_RD] != q.cur_rd) begin
            d.ms = q.rs_en ? M_RS_LOW : M_STOP_LOW;
          end else begin
            ld_data = 1'b1;
            d.bitn  = '0;
            d.ms    = M_LOW;
          end
        end
      end
      M_RS_LOW, M_STOP_LOW: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == SDA_CYC) begin
          d.m_sda_low = (q.ms == M_STOP_LOW);
        end
        if (q.cnt == LOW_CYC) begin
          d.m_scl_low = 1'b0;
          d.ms        = (q.ms == M_STOP_LOW) ? M_STOP_RISE : M_RS_RISE;
        end
      end
      M_RS_RISE: begin
        if (scl_s) begin
          d.ms  = M_RS_HIGH;
          d.cnt = '0;
        end
      end
      M_STOP_RISE: begin
        if (scl_s) begin
          d.ms  = M_STOP_HIGH;
          d.cnt = '0;
        end
      end
      M_RS_HIGH: begin
        // No arbitration check here: a start is never contested
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == HIGH_CYC) begin
          if (!q.m_sda_low) begin
            d.m_sda_low = 1'b1;
            d.cnt       = '0;
          end else begin
            ld_addr = 1'b1;
          end
        end
      end
      M_STOP_HIGH: begin
        d.cnt = q.cnt + 8'h01;
        if (q.cnt == HIGH_CYC) begin
          d.cnt = '0;
          if (q.m_sda_low) begin
            d.m_sda_low = 1'b0;
          end else begin
            d.ms = M_IDLE;
          end
        end
      end
      M_LOST: begin
        d.m_scl_low = 1'b0;
        d.m_sda_low = 1'b0;
        if (!q.bus_busy) begin
          d.ms = M_IDLE;
        end
      end
      default: d.ms = M_IDLE;
    endcase

    if (byte_end) begin
      d.bitn = '0;
      case (q.kind)
        K_SB: d.ms = M_RS_LOW;
        K_ADDR: begin
          if (q.ackb) begin
            d.nack  = 1'b1;
            d.cmd_v = 1'b0;
            d.ms    = M_STOP_LOW;
          end else begin
            ld_data = 1'b1;
            d.ms    = M_LOW;
          end
        end
        default: begin
          if (q.kind == K_RD) begin
            d.rx   = q.sh;
            d.rx_v = 1'b1;
          end
          if (q.kind == K_WR && q.ackb) begin
            d.nack = 1'b1;
            d.ms   = M_STOP_LOW;
          end else begin
            d.ms = q.last ? M_STOP_LOW : M_HOLD;
          end
        end
      endcase
    end
    if (ld_addr) begin
      d.sh        = {q.tar, q.cmd[CMD_RD]};
      d.kind      = K_ADDR;
      d.cur_rd    = q.cmd[CMD_RD];
      d.bitn      = '0;
      d.cnt       = '0;
      d.m_scl_low = 1'b1;
      d.ms        = M_LOW;
    end
    if (ld_data) begin
      d.kind  = q.cmd[CMD_RD] ? K_RD : K_WR;
      d.sh    = q.cmd[7:0];
      d.last  = q.cmd[CMD_STOP];
      d.cmd_v = 1'b0;
    end

    // Slave engine on the synchronised lines at full clock rate
    if (start_det) begin
      d.s_ph  = q.sl_en ? P_ADDR : P_IDLE;
      d.s_bit = 4'hf;
      d.s_low = 1'b0;
    end else if (stop_det) begin
      d.s_ph  = P_IDLE;
      d.s_low = 1'b0;
    end else if (q.s_ph != P_IDLE) begin
      if (sy_rise[0]) begin
        if (!q.s_bit[3]) begin
          d.s_sh = {q.s_sh[6:0], sda_s};
        end else if (q.s_bit == 4'h8 && q.s_ph == P_TX && sda_s) begin
          d.s_ph = P_IGN;
        end
      end
      if (sy_fall[0]) begin
        d.s_low = 1'b0;
        d.s_bit = (nb == 4'h9) ? 4'h0 : nb;
        if (nb == 4'h8) begin
          case (q.s_ph)
            P_ADDR: begin
              // Start byte and general call never match
              if (q.s_sh[7:1] == q.own && q.s_sh[7:1] != 7'h00) begin
                d.s_low = 1'b1;
                d.s_ph  = q.s_sh[0] ? P_TX : P_RX;
              end else begin
                d.s_ph = P_IGN;
              end
            end
            P_RX: begin
              d.slv_rx   = q.s_sh;
              d.slv_rx_v = 1'b1;
              d.s_low    = 1'b1;
            end
            default: d.s_low = 1'b0;
          endcase
        end else if (q.s_ph == P_TX && !nb[3]) begin
          d.s_low = ~q.slv_tx[3'h7 - nb[2:0]];
        end else if (q.s_ph == P_TX && nb == 4'h9) begin
          d.s_low = ~q.slv_tx[7];
        end
      end
    end

    if (wr_fire) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          d.en    = wv[CTRL_EN];
          d.rs_en = wv[CTRL_RSEN];
          d.sb_en = wv[CTRL_SB];
          d.sl_en = wv[CTRL_SLV];
        end
        ADR_TAR: begin
          if (!q.en) begin
            d.tar = wv[6:0];
          end
        end
        ADR_CMD: begin
          if (!q.cmd_v) begin
            d.cmd   = wv[CMD_W-1:0];
            d.cmd_v = 1'b1;
          end
        end
        ADR_SADDR: d.own = wv[6:0];
        ADR_STX:   d.slv_tx = wv[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q       <= '0;
      q.rs_en <= CTRL_RSEN_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o   = q.dat;
  assign wb_ack_o   = q.ack;
  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe_n_o = ~q.m_scl_low;
  assign sda_oe_n_o = ~(q.m_sda_low | q.s_low);

  sequence s_stop_enter;
    q.ms == M_STOP_LOW && $past(q.ms) != M_STOP_LOW;
  endsequence

  sequence s_stop_release;
    ##[1:60] q.ms == M_STOP_RISE && !q.m_scl_low && q.m_sda_low;
  endsequence

  a_hold_scl_low: assert property (@(posedge clk_i) disable iff (rst_i)
    q.ms == M_HOLD |-> !scl_oe_n_o && !$rose(q.nack))
    else $error("SCL not held low while waiting for command");

  a_lost_release: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(q.arb_lost) |-> q.ms == M_LOST && scl_oe_n_o ##1 scl_oe_n_o)
    else $error("Clock still driven after lost arbitration");

  a_rise_waits: assert property (@(posedge clk_i) disable iff (rst_i)
    q.ms == M_RISE && !sy_lvl[0] |=> q.ms == M_RISE && scl_oe_n_o)
    else $error("High count began before SCL rose");

  a_nack_stops: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(q.nack) |-> q.ms == M_STOP_LOW)
    else $error("Missing acknowledge did not lead to stop");

  a_stop_seq: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stop_enter |-> s_stop_release)
    else $error("Stop sequence did not release SCL with SDA low");

  a_slave_release: assert property (@(posedge clk_i) disable iff (rst_i)
    q.s_ph == P_IGN |-> !q.s_low)
    else $error("Ignoring slave drives SDA");

  a_restart_off: assert property (@(posedge clk_i) disable iff (rst_i)
    q.ms == M_HOLD && q.cmd_v && q.cmd[CMD_RS] && !q.rs_en |=> q.ms == M_STOP_LOW)
    else $error("Restart without enable did not stop first");

  a_restart_on: assert property (@(posedge clk_i) disable iff (rst_i)
    q.ms == M_HOLD && q.cmd_v && q.cmd[CMD_RS] && q.rs_en |=> q.ms == M_RS_LOW)
    else $error("Restart flag did not give repeated start");

  a_tar_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    q.en |=> $stable(q.tar))
    else $error("Target address changed while enabled");

  a_no_start_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    q.ms == M_IDLE && q.bus_busy |=> q.ms == M_IDLE)
    else $error("Start attempted on busy bus");
endmodule
`default_nettype wire

// file: sim/tpe_bus_slave.sv
`timescale 1ns/100ps
`default_nettype none
module tpe_bus_slave (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       stretch_i,
  output logic            scl_oe_n_o,
  output logic            sda_oe_n_o,
  output logic [7:0]      last_rx_o,
  output logic [7:0]      rx_cnt_o,
  output logic [7:0]      macks_o,
  output logic [7:0]      mnacks_o
);
  logic       act, adr_ph, rd, ackp;
  logic [3:0] cnt;
  logic [7:0] sh;
  initial begin
    {act, adr_ph, rd, ackp} = 4'h0;
    cnt = 4'h0;
    sh = 8'h00;
    {scl_oe_n_o, sda_oe_n_o} = 2'h3;
    {last_rx_o, rx_cnt_o, macks_o, mnacks_o} = 32'h0;
  end
  // Start or restart drops any byte in flight
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    {act, adr_ph, rd, ackp} = 4'hc;
    cnt = 4'h0;
    sda_oe_n_o = 1'b1;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) act = 1'b0;
  always @(posedge scl_i) if (act) begin
    if (cnt < 4'h8) begin
      sh = {sh[6:0], sda_i};
      cnt++;
      if (cnt == 4'h8 && adr_ph) begin
        ackp = (sh[7:1] == addr_i) && (addr_i != 7'h00);
        rd = sh[0];
        act = ackp;
      end else if (cnt == 4'h8) begin
        ackp = !rd;
        if (!rd) begin
          rx_cnt_o++;
          last_rx_o = sh;
        end
      end
    end else begin
      if (rd && !adr_ph && sda_i) begin
        mnacks_o++;
        act = 1'b0;
      end else if (rd && !adr_ph) macks_o++;
      adr_ph = 1'b0;
      cnt = 4'h0;
    end
  end
  // Data changes only while the clock is low
  always @(negedge scl_i) begin
    if (!act) sda_oe_n_o = 1'b1;
    else if (cnt == 4'h8) sda_oe_n_o = !ackp;
    else if (rd && !adr_ph) sda_oe_n_o = tx_byte_i[3'(7 - cnt)];
    else sda_oe_n_o = 1'b1;
    if (act && cnt == 4'h0 && stretch_i) begin
      scl_oe_n_o = 1'b0;
      #20000;
      scl_oe_n_o = 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tpe_pkg::*;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr, tx_byte, last_rx, rx_cnt, macks, mnacks;
  logic [31:0] wb_wdat, wb_rdat, rdat;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, s_scl_oe_n, s_sda_oe_n, rival_n, stretch;
  wire         scl_w, sda_w;
  int          fails, samples_checked, starts, stops;
  assign scl_w = (scl_oe_n | scl_o) & s_scl_oe_n;
  assign sda_w = (sda_oe_n | sda_o) & s_sda_oe_n & rival_n;
  tpe_host dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(4'hf),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n));
  tpe_bus_slave slv_u (.scl_i(scl_w), .sda_i(sda_w), .addr_i(7'h5a), .tx_byte_i(tx_byte),
    .stretch_i(stretch), .scl_oe_n_o(s_scl_oe_n), .sda_oe_n_o(s_sda_oe_n),
    .last_rx_o(last_rx), .rx_cnt_o(rx_cnt), .macks_o(macks), .mnacks_o(mnacks));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(negedge sda_w) if (scl_w === 1'b1) starts++;
  always @(posedge sda_w) if (scl_w === 1'b1) stops++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Classic cycle; the watchdog bounds every wait
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wbx(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic wait_st(input int b, input logic v);
    do wbx(1'b0, ADR_STATUS, 32'h0); while (rdat[b] !== v);
  endtask
  task automatic idle;
    wait_st(ST_ACTIVE, 1'b0);
    wait_st(ST_BUSY, 1'b0);
  endtask
  task automatic send(input logic [31:0] c);
    wait_st(ST_CMDV, 1'b0);
    wbx(1'b1, ADR_CMD, c);
  endtask
  // Target may only change while disabled
  task automatic cfg(input logic [31:0] ctl, input logic [31:0] tar);
    wbx(1'b1, ADR_CTRL, 32'h0);
    wbx(1'b1, ADR_TAR, tar);
    wbx(1'b1, ADR_CTRL, ctl);
  endtask
  task automatic t_regs;
    rdc(ADR_CTRL, 32'h2);
    rdc(ADR_STATUS, 32'h0);
    wbx(1'b1, 8'h20, 32'hffff_ffff);
    rdc(8'h20, 32'h0);
    cfg(32'h3, 32'h5a);
    wbx(1'b1, ADR_TAR, 32'h11);
    rdc(ADR_TAR, 32'h5a);
  endtask
  task automatic t_write;
    int s0, r0;
    s0 = stops;
    r0 = rx_cnt;
    stretch <= 1'b1;
    send(32'h0a5);
    wait_st(ST_HOLD, 1'b1);
    repeat (300) @(posedge clk_i);
    chk(32'(scl_w), 32'h0);
    chk(32'(stops - s0), 32'h0);
    send(32'h23c);
    idle;
    stretch <= 1'b0;
    chk(32'(rx_cnt - r0), 32'h2);
    chk(32'(last_rx), 32'h3c);
    chk(32'(stops - s0), 32'h1);
  endtask
  task automatic t_read;
    int a0, n0;
    a0 = macks;
    n0 = mnacks;
    send(32'h100);
    send(32'h300);
    wait_st(ST_RXV, 1'b1);
    rdc(ADR_RXDATA, 32'hc3);
    wait_st(ST_RXV, 1'b1);
    rdc(ADR_RXDATA, 32'hc3);
    idle;
    chk(32'(macks - a0), 32'h1);
    chk(32'(mnacks - n0), 32'h1);
  endtask
  task automatic t_nack;
    int s0;
    cfg(32'h3, 32'h33);
    s0 = stops;
    send(32'h2aa);
    idle;
    chk(32'(stops - s0), 32'h1);
    rdc(ADR_STATUS, 32'h4);
    wbx(1'b1, ADR_STATUS, 32'h4);
    rdc(ADR_STATUS, 32'h0);
    cfg(32'h3, 32'h5a);
  endtask
  // Restart on, restart off, start byte prefix
  task automatic t_restart;
    logic [31:0] ctl [3] = '{32'h3, 32'h1, 32'h7};
    int          est [3] = '{2, 2, 3};
    int          esp [3] = '{1, 2, 1};
    int          s0, p0, r0;
    for (int i = 0; i < 3; i++) begin
      wbx(1'b1, ADR_CTRL, ctl[i]);
      s0 = starts;
      p0 = stops;
      r0 = rx_cnt;
      send(32'h0a5);
      send(32'h700);
      wait_st(ST_RXV, 1'b1);
      rdc(ADR_RXDATA, 32'hc3);
      idle;
      chk(32'(starts - s0), 32'(est[i]));
      chk(32'(stops - p0), 32'(esp[i]));
      chk(32'(rx_cnt - r0), 32'h1);
    end
  endtask
  task automatic t_arb;
    cfg(32'h3, 32'h7f);
    // Another master owns the bus first
    rival_n <= 1'b0;
    send(32'h2ff);
    repeat (300) @(posedge clk_i);
    chk(32'(scl_w), 32'h1);
    rdc(ADR_STATUS, 32'h11);
    rival_n <= 1'b1;
    @(negedge scl_w);
    @(posedge clk_i);
    rival_n <= 1'b0;
    wait_st(ST_ARB, 1'b1);
    repeat (200) @(posedge clk_i);
    chk(32'({scl_oe_n, sda_oe_n}), 32'h3);
    chk(32'(scl_w), 32'h1);
    rival_n <= 1'b1;
    idle;
    wbx(1'b1, ADR_STATUS, 32'h8);
    rdc(ADR_STATUS, 32'h0);
  endtask
  // Own slave answers its own master; bit 7 of STX low exposes a stuck release
  task automatic t_slave;
    int p0;
    wbx(1'b1, ADR_SADDR, 32'h21);
    wbx(1'b1, ADR_STX, 32'h69);
    cfg(32'hf, 32'h21);
    p0 = stops;
    send(32'h0e7);
    send(32'h700);
    idle;
    chk(32'(stops - p0), 32'h1);
    rdc(ADR_STATUS, 32'h42);
    rdc(ADR_SRX, 32'he7);
    rdc(ADR_RXDATA, 32'h69);
    rdc(ADR_STATUS, 32'h0);
  endtask
  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, rival_n, stretch} = 6'h22;
    wb_adr = 8'h00;
    wb_wdat = 32'h0;
    tx_byte = 8'hc3;
    {fails, samples_checked, starts, stops} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_write;
    t_read;
    t_nack;
    t_restart;
    t_arb;
    t_slave;
    wrap_up;
  end
  // About three times the expected run
  initial begin
    #8000000;
    fails++;
    wrap_up;
  end
endmodule
`default_nettype wire
